// File: csc_pkg.sv
// Purpose: Shared constants for the coherent snoop channel port
// Assumes: One clock, synchronous active-high reset
// Notes:   Domain codes and cache attribute bit positions
package csc_pkg;

   // ==========================================================
   // Widths
   // ==========================================================
   localparam int ADDR_W_DEF  = 32;
   localparam int DATA_W_DEF  = 64;
   localparam int SNOOP_W     = 4;
   localparam int PROT_W      = 3;
   localparam int RESP_W      = 5;
   localparam int CACHE_W     = 4;
   localparam int DOMAIN_W    = 2;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int PROT_NS_BIT   = 1;
   localparam int CACHE_MOD_BIT = 1;
   localparam int CACHE_ALC_LO  = 2;
   localparam int CACHE_ALC_HI  = 3;

   // ==========================================================
   // Shareability domain encodings
   // ==========================================================
   localparam logic [1:0] DOM_NSH = 2'h0;
   localparam logic [1:0] DOM_ISH = 2'h1;
   localparam logic [1:0] DOM_OSH = 2'h2;
   localparam logic [1:0] DOM_SYS = 2'h3;

   // ==========================================================
   // Values after reset
   // ==========================================================
   localparam logic       RST_VALID  = 1'b0;
   localparam logic       RST_ACK    = 1'b0;
   localparam logic [3:0] RST_CACHE  = 4'h0;
   localparam logic [1:0] RST_DOMAIN = 2'h3;

endpackage

// File: csc_if.sv
// Purpose: Snoop, acknowledge and attribute wires between master and interconnect
// Assumes: Both ends clocked by the same clock
// Notes:   Snoop address width equals read and write address width
`timescale 1ns/100ps
interface csc_if #(
   parameter int ADDR_W = 32,
   parameter int DATA_W = 64
) ();
   import csc_pkg::*;

   logic                acvalid;
   logic                acready;
   logic [ADDR_W-1:0]   acaddr;
   logic [SNOOP_W-1:0]  acsnoop;
   logic [PROT_W-1:0]   acprot;
   logic                crvalid;
   logic                crready;
   logic [RESP_W-1:0]   crresp;
   logic                cdvalid;
   logic                cdready;
   logic [DATA_W-1:0]   cddata;
   logic                cdlast;
   logic                rack;
   logic                wack;
   logic [CACHE_W-1:0]  arcache;
   logic [DOMAIN_W-1:0] ardomain;
   logic [CACHE_W-1:0]  awcache;
   logic [DOMAIN_W-1:0] awdomain;

   modport master (
      input  acvalid, acaddr, acsnoop, acprot, crready, cdready,
      output acready, crvalid, crresp, cdvalid, cddata, cdlast, rack, wack,
      output arcache, ardomain, awcache, awdomain
   );

   modport icn (
      output acvalid, acaddr, acsnoop, acprot, crready, cdready,
      input  acready, crvalid, crresp, cdvalid, cddata, cdlast, rack, wack,
      input  arcache, ardomain, awcache, awdomain
   );
endinterface

// File: csc_icn.sv
// Purpose: Interconnect end: issues snoops, takes responses, data and acks
// Assumes: Same clock as the master end
// Notes:   Reports which caches each read and write attribute pair reaches
`timescale 1ns/100ps
module csc_icn
   import csc_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int DATA_W = DATA_W_DEF
) (
   input  wire logic                I_CLOCK,      // Clock
   input  wire logic                I_SRST,       // Sync reset, high
   csc_if.icn                       bus,          // Link to master
   input  wire logic                I_SNP_VALID,  // Snoop request
   output logic                     O_SNP_READY,  // Snoop slot free
   input  wire logic [ADDR_W-1:0]   I_SNP_ADDR,   // Snoop address
   input  wire logic [SNOOP_W-1:0]  I_SNP_TYPE,   // Snoop type
   input  wire logic [PROT_W-1:0]   I_SNP_PROT,   // Snoop protection
   output logic                     O_RSP_VALID,  // Response held
   input  wire logic                I_RSP_READY,  // Response taken
   output logic [RESP_W-1:0]        O_RSP_CODE,   // Response code
   output logic                     O_DAT_VALID,  // Data beat held
   input  wire logic                I_DAT_READY,  // Data beat taken
   output logic [DATA_W-1:0]        O_DAT_DATA,   // Data beat
   output logic                     O_DAT_LAST,   // Last beat
   output logic                     O_RD_ACK,     // Read ack pulse
   output logic                     O_WR_ACK,     // Write ack pulse
   output logic [1:0]               O_AR_ROUTE,   // Read {peer,down}
   output logic [1:0]               O_AW_ROUTE    // Write {peer,down}
);

   // ==========================================================
   // Cache reach decode
   // ==========================================================
   function automatic logic [1:0] route(input logic [CACHE_W-1:0] c, input logic [1:0] d);
      logic peer;
      logic down;
      peer = c[CACHE_MOD_BIT] && (d == DOM_ISH || d == DOM_OSH);
      down = (c[CACHE_ALC_HI:CACHE_ALC_LO] != 2'h0) && (d != DOM_SYS);
      return {peer, down};
   endfunction

   wire logic [1:0] ar_route = route(bus.arcache, bus.ardomain);
   wire logic [1:0] aw_route = route(bus.awcache, bus.awdomain);

   // ==========================================================
   // Snoop address issue
   // ==========================================================
   logic              ac_valid_ff;
   logic [ADDR_W-1:0] ac_addr_ff;
   logic [SNOOP_W-1:0] ac_snoop_ff;
   logic [PROT_W-1:0] ac_prot_ff;
   logic              snp_ready_ff;

   wire logic ac_fire  = ac_valid_ff & bus.acready;
   wire logic snp_load = I_SNP_VALID & snp_ready_ff;
   wire logic nxt_ac_valid = snp_load | (ac_valid_ff & ~ac_fire);

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         ac_valid_ff  <= RST_VALID;
         snp_ready_ff <= 1'b0;
      end
      else
      begin
         ac_valid_ff  <= nxt_ac_valid;
         snp_ready_ff <= ~nxt_ac_valid;
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (snp_load)
      begin
         ac_addr_ff  <= I_SNP_ADDR;
         ac_snoop_ff <= I_SNP_TYPE;
         ac_prot_ff  <= I_SNP_PROT;
      end
   end

   // ==========================================================
   // Response and data capture
   // ==========================================================
   logic              rsp_valid_ff;
   logic [RESP_W-1:0] rsp_code_ff;
   logic              dat_valid_ff;
   logic [DATA_W-1:0] dat_data_ff;
   logic              dat_last_ff;
   logic              crready_ff;
   logic              cdready_ff;
   logic              rd_ack_ff;
   logic              wr_ack_ff;
   logic [1:0]        ar_route_ff;
   logic [1:0]        aw_route_ff;

   wire logic cr_fire = bus.crvalid & crready_ff;
   wire logic cd_fire = bus.cdvalid & cdready_ff;
   wire logic nxt_rsp_valid = cr_fire | (rsp_valid_ff & ~I_RSP_READY);
   wire logic nxt_dat_valid = cd_fire | (dat_valid_ff & ~I_DAT_READY);

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         rsp_valid_ff <= RST_VALID;
         dat_valid_ff <= RST_VALID;
         crready_ff   <= 1'b0;
         cdready_ff   <= 1'b0;
         rd_ack_ff    <= RST_ACK;
         wr_ack_ff    <= RST_ACK;
         ar_route_ff  <= 2'h0;
         aw_route_ff  <= 2'h0;
      end
      else
      begin
         rsp_valid_ff <= nxt_rsp_valid;
         dat_valid_ff <= nxt_dat_valid;
         crready_ff   <= ~nxt_rsp_valid;
         cdready_ff   <= ~nxt_dat_valid;
         rd_ack_ff    <= bus.rack;
         wr_ack_ff    <= bus.wack;
         ar_route_ff  <= ar_route;
         aw_route_ff  <= aw_route;
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (cr_fire)
         rsp_code_ff <= bus.crresp;
      if (cd_fire)
      begin
         dat_data_ff <= bus.cddata;
         dat_last_ff <= bus.cdlast;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign bus.acvalid = ac_valid_ff;
   assign bus.acaddr  = ac_addr_ff;
   assign bus.acsnoop = ac_snoop_ff;
   assign bus.acprot  = ac_prot_ff;
   assign bus.crready = crready_ff;
   assign bus.cdready = cdready_ff;
   assign O_SNP_READY = snp_ready_ff;
   assign O_RSP_VALID = rsp_valid_ff;
   assign O_RSP_CODE  = rsp_code_ff;
   assign O_DAT_VALID = dat_valid_ff;
   assign O_DAT_DATA  = dat_data_ff;
   assign O_DAT_LAST  = dat_last_ff;
   assign O_RD_ACK    = rd_ack_ff;
   assign O_WR_ACK    = wr_ack_ff;
   assign O_AR_ROUTE  = ar_route_ff;
   assign O_AW_ROUTE  = aw_route_ff;

endmodule

// File: csc_master.sv
// Purpose: Master end of the coherent snoop channels and acknowledges
// Assumes: Same clock as the interconnect end; user logic is synchronous
// Notes:   Snoop data passes a two-entry buffer; domains are made legal
//
// How it works
// - Snoop address valid/ready handshake both ways
// - Snoop address width equals AR/AW width
// - Interconnect drives four-bit snoop type
// - Only protection bit one is used
// - Response valid with five-bit code, ready back
// - Data beats with last flag, ready back
// - Read done gives read acknowledge
// - Write response taken gives write acknowledge
// - Reset holds acks and response/data valids low
// - Interconnect holds snoop valid low in reset
// - Snoop valid only after reset released
// - Domain codes: non, inner, outer, system
// - Domains nest from single master to system
// - Domain membership agreed system wide
// - Device access uses system domain only
// - Cacheable access never uses system domain; the code still sets system when cache bit one is low
// - Cacheable reaches downstream and matching peer caches
// - Non-cacheable reaches only matching peer caches
`timescale 1ns/100ps
module csc_master
   import csc_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int DATA_W = DATA_W_DEF
) (
   input  wire logic                 I_CLOCK,      // Clock
   input  wire logic                 I_SRST,       // Sync reset, high
   csc_if.master                     bus,          // Link to interconnect
   output logic                      O_SNP_VALID,  // Snoop held for user
   input  wire logic                 I_SNP_READY,  // User takes snoop
   output logic [ADDR_W-1:0]         O_SNP_ADDR,   // Snoop address
   output logic [SNOOP_W-1:0]        O_SNP_TYPE,   // Snoop type
   output logic                      O_SNP_NONSEC, // Protection bit one
   input  wire logic                 I_RSP_VALID,  // User response
   output logic                      O_RSP_READY,  // Response slot free
   input  wire logic [RESP_W-1:0]    I_RSP_CODE,   // Response code
   input  wire logic                 I_DAT_VALID,  // User data beat
   output logic                      O_DAT_READY,  // Buffer has room
   input  wire logic [DATA_W-1:0]    I_DAT_DATA,   // Data beat
   input  wire logic                 I_DAT_LAST,   // Last beat
   input  wire logic                 I_RD_DONE,    // Read finished pulse
   input  wire logic                 I_WR_DONE,    // Write resp taken pulse
   input  wire logic [CACHE_W-1:0]   I_AR_CACHE,   // Read cache attrs
   input  wire logic [DOMAIN_W-1:0]  I_AR_DOMAIN,  // Read domain asked
   input  wire logic [CACHE_W-1:0]   I_AW_CACHE,   // Write cache attrs
   input  wire logic [DOMAIN_W-1:0]  I_AW_DOMAIN,  // Write domain asked
   output logic                      O_AR_FIXED,   // Read domain corrected
   output logic                      O_AW_FIXED    // Write domain corrected
);

   // ==========================================================
   // Domain legalising
   // ==========================================================
   function automatic logic [1:0] legal_dom(input logic [CACHE_W-1:0] c, input logic [1:0] d);
      logic [1:0] r;
      r = d;
      if (!c[CACHE_MOD_BIT])
         r = DOM_SYS;
      else if ((c[CACHE_ALC_HI:CACHE_ALC_LO] != 2'h0) && (d == DOM_SYS))
         r = DOM_OSH;
      return r;
   endfunction

   wire logic [1:0] ar_dom = legal_dom(I_AR_CACHE, I_AR_DOMAIN);
   wire logic [1:0] aw_dom = legal_dom(I_AW_CACHE, I_AW_DOMAIN);

   logic [CACHE_W-1:0]  arcache_ff;
   logic [DOMAIN_W-1:0] ardomain_ff;
   logic [CACHE_W-1:0]  awcache_ff;
   logic [DOMAIN_W-1:0] awdomain_ff;
   logic                ar_fixed_ff;
   logic                aw_fixed_ff;

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         arcache_ff  <= RST_CACHE;
         ardomain_ff <= RST_DOMAIN;
         awcache_ff  <= RST_CACHE;
         awdomain_ff <= RST_DOMAIN;
         ar_fixed_ff <= 1'b0;
         aw_fixed_ff <= 1'b0;
      end
      else
      begin
         arcache_ff  <= I_AR_CACHE;
         ardomain_ff <= ar_dom;
         awcache_ff  <= I_AW_CACHE;
         awdomain_ff <= aw_dom;
         ar_fixed_ff <= (ar_dom != I_AR_DOMAIN);
         aw_fixed_ff <= (aw_dom != I_AW_DOMAIN);
      end
   end

   // ==========================================================
   // Snoop address capture
   // ==========================================================
   logic               snp_valid_ff;
   logic               acready_ff;
   logic [ADDR_W-1:0]  snp_addr_ff;
   logic [SNOOP_W-1:0] snp_type_ff;
   logic               snp_nonsec_ff;

   wire logic ac_fire  = bus.acvalid & acready_ff;
   wire logic snp_take = snp_valid_ff & I_SNP_READY;
   wire logic nxt_snp_valid = ac_fire | (snp_valid_ff & ~snp_take);

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         snp_valid_ff <= RST_VALID;
         acready_ff   <= 1'b0;
      end
      else
      begin
         snp_valid_ff <= nxt_snp_valid;
         acready_ff   <= ~nxt_snp_valid;
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (ac_fire)
      begin
         snp_addr_ff   <= bus.acaddr;
         snp_type_ff   <= bus.acsnoop;
         snp_nonsec_ff <= bus.acprot[PROT_NS_BIT];
      end
   end

   // ==========================================================
   // Snoop response
   // ==========================================================
   logic              crvalid_ff;
   logic [RESP_W-1:0] crresp_ff;

   wire logic rsp_load = I_RSP_VALID & ~crvalid_ff;
   wire logic cr_fire  = crvalid_ff & bus.crready;

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
         crvalid_ff <= RST_VALID;
      else
         crvalid_ff <= rsp_load | (crvalid_ff & ~cr_fire);
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (rsp_load)
         crresp_ff <= I_RSP_CODE;
   end

   // ==========================================================
   // Snoop data two-entry buffer
   // ==========================================================
   logic              head_v_ff;
   logic [DATA_W-1:0] head_d_ff;
   logic              head_l_ff;
   logic              skid_v_ff;
   logic [DATA_W-1:0] skid_d_ff;
   logic              skid_l_ff;

   wire logic dat_push  = I_DAT_VALID & ~skid_v_ff;
   wire logic cd_pop    = head_v_ff & bus.cdready;
   wire logic head_free = cd_pop | ~head_v_ff;
   wire logic from_skid = head_free & skid_v_ff;
   wire logic from_in   = head_free & ~skid_v_ff & dat_push;
   wire logic to_skid   = dat_push & ~from_in;
   wire logic nxt_head_v = head_free ? (skid_v_ff | dat_push) : 1'b1;
   wire logic nxt_skid_v = to_skid | (skid_v_ff & ~from_skid);

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         head_v_ff <= RST_VALID;
         skid_v_ff <= RST_VALID;
      end
      else
      begin
         head_v_ff <= nxt_head_v;
         skid_v_ff <= nxt_skid_v;
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (from_skid)
      begin
         head_d_ff <= skid_d_ff;
         head_l_ff <= skid_l_ff;
      end
      else if (from_in)
      begin
         head_d_ff <= I_DAT_DATA;
         head_l_ff <= I_DAT_LAST;
      end
      if (to_skid)
      begin
         skid_d_ff <= I_DAT_DATA;
         skid_l_ff <= I_DAT_LAST;
      end
   end

   // ==========================================================
   // Read and write acknowledges
   // ==========================================================
   logic rack_ff;
   logic wack_ff;

   always_ff @(posedge I_CLOCK)
   begin
      if (I_SRST)
      begin
         rack_ff <= RST_ACK;
         wack_ff <= RST_ACK;
      end
      else
      begin
         rack_ff <= I_RD_DONE;
         wack_ff <= I_WR_DONE;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign bus.acready  = acready_ff;
   assign bus.crvalid  = crvalid_ff;
   assign bus.crresp   = crresp_ff;
   assign bus.cdvalid  = head_v_ff;
   assign bus.cddata   = head_d_ff;
   assign bus.cdlast   = head_l_ff;
   assign bus.rack     = rack_ff;
   assign bus.wack     = wack_ff;
   assign bus.arcache  = arcache_ff;
   assign bus.ardomain = ardomain_ff;
   assign bus.awcache  = awcache_ff;
   assign bus.awdomain = awdomain_ff;

   assign O_SNP_VALID  = snp_valid_ff;
   assign O_SNP_ADDR   = snp_addr_ff;
   assign O_SNP_TYPE   = snp_type_ff;
   assign O_SNP_NONSEC = snp_nonsec_ff;
   assign O_RSP_READY  = ~crvalid_ff;
   assign O_DAT_READY  = ~skid_v_ff;
   assign O_AR_FIXED   = ar_fixed_ff;
   assign O_AW_FIXED   = aw_fixed_ff;

endmodule

// File: csc_properties.sv
// Purpose: Assertions on the snoop channels
// Assumes: One clock, sync reset high
// Notes:   Watches interface signals only
`timescale 1ns/100ps
module csc_props
   import csc_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter int DATA_W = 64
) (
   input wire logic              I_CLOCK, I_SRST, acvalid, acready, crvalid, crready,
   input wire logic              cdvalid, cdready, cdlast, rack, wack,
   input wire logic [ADDR_W-1:0] acaddr,
   input wire logic [3:0]        acsnoop, arcache, awcache,
   input wire logic [2:0]        acprot,
   input wire logic [4:0]        crresp,
   input wire logic [DATA_W-1:0] cddata,
   input wire logic [1:0]        ardomain, awdomain
);
   // ==========================================================
   // Properties
   // ==========================================================
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_SRST);
   sequence s_ac_idle;
      !acvalid ##1 !acvalid;
   endsequence
   sequence s_ac_kept;
      acvalid && $stable(acaddr) && $stable(acsnoop) && $stable(acprot);
   endsequence
   rst_quiet_a:
      assert property (disable iff (1'b0) I_SRST |=> !(crvalid || cdvalid || rack || wack || acvalid))
      else $error("valid or ack high in reset");
   ac_start_a:
      assert property ($fell(I_SRST) |-> s_ac_idle) else $error("snoop valid too soon");
   ac_hold_a:
      assert property (acvalid && !acready |=> s_ac_kept) else $error("snoop changed before ready");
   ac_take_a:
      assert property (acvalid && acready |=> !acready) else $error("snoop slot not closed");
   cr_hold_a:
      assert property (crvalid && !crready |=> crvalid && $stable(crresp)) else $error("response dropped");
   cr_take_a:
      assert property (crvalid && crready |=> !crvalid) else $error("response not retired");
   cd_hold_a:
      assert property (cdvalid && !cdready |=> cdvalid && $stable({cdlast, cddata})) else $error("beat dropped");
   dom_dev_a:
      assert property ((arcache[1] || ardomain == DOM_SYS) && (awcache[1] || awdomain == DOM_SYS))
      else $error("device access not system");
   dom_cache_a:
      assert property (!((|arcache[3:2] && ardomain == DOM_SYS) || (|awcache[3:2] && awdomain == DOM_SYS)))
      else $error("cacheable access in system");
endmodule

// File: coherent_snoop_channel_port_test.sv
// Purpose: Bench joining both ends of the snoop channels
// Assumes: 200 MHz clock, sync reset high
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/100ps
module coherent_snoop_channel_port_test;
   import csc_pkg::*;
   // ==========================================================
   // Signals
   // ==========================================================
   logic        clk, srst, s_valid, s_ready, u_valid, u_ready, u_nonsec, r_valid, r_ready, q_valid, q_ready;
   logic        d_valid, d_ready, d_last, e_valid, e_ready, e_last, rd_done, wr_done, rd_ack, wr_ack;
   logic        ar_fixed, aw_fixed;
   logic [31:0] s_addr, u_addr;
   logic [3:0]  s_type, u_type, ar_cache, aw_cache;
   logic [2:0]  s_prot;
   logic [4:0]  r_code, q_code;
   logic [63:0] d_data, e_data;
   logic [1:0]  ar_dom, aw_dom, ar_route, aw_route;
   logic [64:0] q[$];
   logic [3:0]  cv[10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hA, 4'hB, 4'hE, 4'hF};
   int          n_fail, cmp_count, n_rd, n_wr, i, n_got;
   bit          ok;
   csc_if #(.ADDR_W(32), .DATA_W(64)) i_csc_if ();
   wire [5:0]   ar_bus = {i_csc_if.arcache, i_csc_if.ardomain};
   wire [5:0]   aw_bus = {i_csc_if.awcache, i_csc_if.awdomain};
   csc_master i_csc_master (
      .I_CLOCK(clk), .I_SRST(srst), .bus(i_csc_if.master), .O_SNP_VALID(u_valid), .I_SNP_READY(u_ready),
      .O_SNP_ADDR(u_addr), .O_SNP_TYPE(u_type), .O_SNP_NONSEC(u_nonsec), .I_RSP_VALID(r_valid),
      .O_RSP_READY(r_ready), .I_RSP_CODE(r_code), .I_DAT_VALID(d_valid), .O_DAT_READY(d_ready),
      .I_DAT_DATA(d_data), .I_DAT_LAST(d_last), .I_RD_DONE(rd_done), .I_WR_DONE(wr_done),
      .I_AR_CACHE(ar_cache), .I_AR_DOMAIN(ar_dom), .I_AW_CACHE(aw_cache), .I_AW_DOMAIN(aw_dom),
      .O_AR_FIXED(ar_fixed), .O_AW_FIXED(aw_fixed));
   csc_icn i_csc_icn (
      .I_CLOCK(clk), .I_SRST(srst), .bus(i_csc_if.icn), .I_SNP_VALID(s_valid), .O_SNP_READY(s_ready),
      .I_SNP_ADDR(s_addr), .I_SNP_TYPE(s_type), .I_SNP_PROT(s_prot), .O_RSP_VALID(q_valid),
      .I_RSP_READY(q_ready), .O_RSP_CODE(q_code), .O_DAT_VALID(e_valid), .I_DAT_READY(e_ready),
      .O_DAT_DATA(e_data), .O_DAT_LAST(e_last), .O_RD_ACK(rd_ack), .O_WR_ACK(wr_ack),
      .O_AR_ROUTE(ar_route), .O_AW_ROUTE(aw_route));
   csc_props #(.ADDR_W(32), .DATA_W(64)) i_csc_props (
      .I_CLOCK(clk), .I_SRST(srst), .acvalid(i_csc_if.acvalid), .acready(i_csc_if.acready),
      .crvalid(i_csc_if.crvalid), .crready(i_csc_if.crready), .cdvalid(i_csc_if.cdvalid),
      .cdready(i_csc_if.cdready), .cdlast(i_csc_if.cdlast), .rack(i_csc_if.rack), .wack(i_csc_if.wack),
      .acaddr(i_csc_if.acaddr), .acsnoop(i_csc_if.acsnoop), .arcache(i_csc_if.arcache),
      .awcache(i_csc_if.awcache), .acprot(i_csc_if.acprot), .crresp(i_csc_if.crresp),
      .cddata(i_csc_if.cddata), .ardomain(i_csc_if.ardomain), .awdomain(i_csc_if.awdomain));
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   always @(posedge clk)
   begin
      n_rd <= n_rd + int'(rd_ack);
      n_wr <= n_wr + int'(wr_ack);
   end
   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [71:0] got, input logic [71:0] exp, input string what);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   // {fixed, peer, down, cache, domain} after legalising
   function automatic logic [8:0] fx(input logic [3:0] c, input logic [1:0] d);
      logic [1:0] e;
      e = !c[1] ? DOM_SYS : ((c[3:2] != 2'h0 && d == DOM_SYS) ? DOM_OSH : d);
      return {e != d, c[1] && (e == DOM_ISH || e == DOM_OSH), c[3:2] != 2'h0 && e != DOM_SYS, c, e};
   endfunction
   function automatic logic flag(input int w);
      case (w)
         0: return s_ready;
         1: return u_valid;
         2: return r_ready;
         3: return q_valid;
         default: return d_ready;
      endcase
   endfunction
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clk);
         #1;
      end
   endtask
   // Waits for a flag sampled high at an edge
   task automatic await(input int w, input int lim, output bit hit);
      int c;
      c = 0;
      do
      begin
         @(posedge clk);
         c++;
      end
      while (flag(w) !== 1'b1 && c < lim);
      hit = (flag(w) === 1'b1);
      #1;
   endtask
   task automatic snoop(input logic [31:0] a, input logic [3:0] t, input logic [2:0] p);
      s_addr = a;
      s_type = t;
      s_prot = p;
      s_valid = 1'b1;
      await(0, 40, ok);
      s_valid = 1'b0;
      await(1, 40, ok);
      check(u_addr, a, "snoop addr");
      check(u_type, t, "snoop type");
      check(u_nonsec, p[1], "snoop prot");
      tick(1);
      check(u_valid, 1'b1, "snoop held");
      u_ready = 1'b1;
      tick(1);
      u_ready = 1'b0;
      check(u_valid, 1'b0, "snoop taken");
   endtask
   task automatic resp(input logic [4:0] c);
      r_code = c;
      r_valid = 1'b1;
      await(2, 40, ok);
      r_valid = 1'b0;
      await(3, 40, ok);
      check(q_code, c, "resp code");
      tick(1);
      check(q_valid, 1'b1, "resp held");
      q_ready = 1'b1;
      tick(1);
      q_ready = 1'b0;
   endtask
   task automatic push(input int n, input bit fresh, input int lim, output bit hit);
      if (fresh)
      begin
         d_data = 64'hA5A5_0000_0000_0000 | 64'(n);
         d_last = (n % 3 == 2);
         q.push_back({d_last, d_data});
      end
      d_valid = 1'b1;
      await(4, lim, hit);
   endtask
   // Receiver stalls every other cycle
   task automatic drain();
      int c;
      c = 0;
      n_got = 0;
      while (n_got < 6 && c < 200)
      begin
         @(posedge clk);
         c++;
         if (e_valid === 1'b1 && e_ready === 1'b1)
         begin
            check({e_last, e_data}, q.pop_front(), "data beat");
            n_got++;
         end
         #1;
         e_ready = ~e_ready;
      end
   endtask
   // ==========================================================
   // Tests
   // ==========================================================
   initial
   begin
      #25000;
      n_fail++;
      $display("wrong value at %0t: watchdog expired", $time);
      test_done;
   end
   initial
   begin
      {s_valid, u_ready, r_valid, q_ready, d_valid, e_ready, rd_done, wr_done} = 8'h0;
      {s_addr, s_type, s_prot, r_code, d_data, d_last} = '0;
      {ar_cache, aw_cache, ar_dom, aw_dom} = 12'h0;
      {n_fail, cmp_count, n_rd, n_wr} = '0;
      srst = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      check({i_csc_if.acvalid, i_csc_if.crvalid, i_csc_if.cdvalid, i_csc_if.rack, i_csc_if.wack}, 5'h0, "reset");
      srst = 1'b0;
      tick(1);
      for (i = 0; i < 16; i++)
         snoop(32'h8000_0000 | (i << 6), 4'(i), 3'(i));
      $display("test snoop done");
      for (i = 0; i < 4; i++)
         resp(5'(i * 11));
      // Second snoop and response stall behind ones the users still hold
      {s_valid, r_valid} = 2'h3;
      tick(8);
      {s_valid, r_valid} = 2'h0;
      check({s_ready, r_ready}, 2'h0, "stalled");
      {u_ready, q_ready} = 2'h3;
      tick(4);
      {u_ready, q_ready} = 2'h0;
      check({u_valid, q_valid}, 2'h0, "drained");
      $display("test response done");
      for (i = 0; i < 6; i++)
      begin
         push(i, 1'b1, 8, ok);
         if (!ok)
            break;
      end
      check(d_ready, 1'b0, "buffer refuses");
      fork
         begin
            push(i, 1'b0, 40, ok);
            for (i = i + 1; i < 6; i++)
               push(i, 1'b1, 40, ok);
            d_valid = 1'b0;
         end
         drain();
      join
      $display("test data done");
      n_rd = 0;
      n_wr = 0;
      rd_done = 1'b1;
      wr_done = 1'b1;
      tick(1);
      check({i_csc_if.rack, i_csc_if.wack}, 2'h3, "ack pulses");
      wr_done = 1'b0;
      tick(1);
      rd_done = 1'b0;
      check({rd_ack, wr_ack}, 2'h3, "ack passed on");
      tick(4);
      check({n_rd[3:0], n_wr[3:0]}, 8'h21, "ack count");
      $display("test ack done");
      for (i = 0; i < 40; i++)
      begin
         ar_cache = cv[i / 4];
         ar_dom = 2'(i);
         aw_cache = cv[9 - i / 4];
         aw_dom = ~2'(i);
         tick(2);
         check({ar_fixed, ar_route, ar_bus}, fx(ar_cache, ar_dom), "read");
         check({aw_fixed, aw_route, aw_bus}, fx(aw_cache, aw_dom), "write");
      end
      $display("test attributes done");
      test_done;
   end
endmodule
